// >>> design/ssbr_pkg.sv
// constants and types shared by the serial status byte reporter
package ssbr_pkg;

	// status byte layout
	localparam int          SSBR_STAT_W       = 8;
	localparam int          SSBR_BIT_RSV_HI   = 7;
	localparam int          SSBR_BIT_OSC      = 6;
	localparam int          SSBR_BIT_UNDERRUN = 5;
	localparam int          SSBR_BIT_CIPHER   = 4;
	localparam int          SSBR_BIT_TX_ACT   = 3;
	localparam int          SSBR_BIT_LOCK     = 2;
	localparam int          SSBR_BIT_RSSI     = 1;
	localparam int          SSBR_BIT_RSV_LO   = 0;
	localparam logic [7:0]  SSBR_STAT_RESET   = 8'h00;

	// access header layout
	localparam int          SSBR_HDR_RAM_BIT  = 7;
	localparam int          SSBR_HDR_RW_BIT   = 6;
	localparam logic [5:0]  SSBR_STROBE_MAX   = 6'h0E;
	localparam logic [5:0]  SSBR_NOOP_STROBE  = 6'h00;
	localparam logic [5:0]  SSBR_OSC_START    = 6'h01;
	localparam logic [5:0]  SSBR_FLUSH_TX     = 6'h09;
	localparam logic [5:0]  SSBR_TXBUF_ADDR   = 6'h3E;
	localparam logic [5:0]  SSBR_RXBUF_ADDR   = 6'h3F;
	localparam logic [1:0]  SSBR_REG_LAST     = 2'h1;
	localparam logic [2:0]  SSBR_BIT_LAST     = 3'h7;

	// signal strength settle time
	localparam int          SSBR_CLK_PERIOD_PS = 5000;
	localparam int          SSBR_RSSI_SETTLE_US = 128;
	localparam int          SSBR_RSSI_SETTLE_CYC =
		SSBR_RSSI_SETTLE_US * 1000000 / SSBR_CLK_PERIOD_PS;
	localparam int          SSBR_RSSI_CNT_W    = 15;

	typedef enum logic [2:0] {
		SSBR_PH_HDR,
		SSBR_PH_REG,
		SSBR_PH_RAM2,
		SSBR_PH_DATA,
		SSBR_PH_TXW
	} ssbr_phase_t;

	// header byte names a command strobe
	function automatic logic ssbr_is_strobe(input logic [7:0] hdr);
		return !hdr[SSBR_HDR_RAM_BIT] && !hdr[SSBR_HDR_RW_BIT] &&
			(hdr[5:0] <= SSBR_STROBE_MAX);
	endfunction

endpackage

// >>> design/ssbr_status_reporter.sv
// status byte reporter of the four-wire serial configuration port
// Function
// [R1] status out during header, strobe, first RAM address byte
// [R2] status out on every transmit buffer write byte
// [R3] no-op strobe returns status, does nothing
// [R4] bit 6 shows oscillator running
// [R5] bit 5 underflow, sticky until flush strobe
// [R6] bit 4 shows cipher engine busy
// [R7] bit 3 shows transmission active
// [R8] bit 2 shows synthesizer lock
// [R9] bit 1 valid after 128 us receive
// [R10] bits 7 and 0 reserved, host ignores
// [R11] strobe is write header, runs last fall
// [R12] oscillator off: only start strobe accepted
// [R13] status shifts out MSB first, bit per clock
`timescale 1ns/1ps

module ssbr_status_reporter
	import ssbr_pkg::*;
#(
	parameter logic [SSBR_RSSI_CNT_W-1:0] RSSI_SETTLE_CYC =
		SSBR_RSSI_CNT_W'(SSBR_RSSI_SETTLE_CYC)
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       sclk,
	input  wire logic       chip_select_n,
	input  wire logic       si,
	output logic            so,
	output logic            so_oe,
	input  wire logic       osc_running,
	input  wire logic       tx_underflow_evt,
	input  wire logic       cipher_busy,
	input  wire logic       tx_active,
	input  wire logic       pll_locked,
	input  wire logic       rx_enabled,
	input  wire logic       rssi_ready,
	output logic            strobe_valid,
	output logic [5:0]      strobe_code,
	output logic [7:0]      status_byte
);

	////////////////////////////////////////////////////////////////////////////
	// system clock side: status byte

	logic [7:0]                 status_r;
	logic [SSBR_RSSI_CNT_W-1:0] rx_cnt_r;
	logic                       stb_s1_r;
	logic                       stb_s2_r;
	logic                       stb_s3_r;
	logic                       stb_evt;
	logic                       stb_accept;
	logic                       flush_acc;
	logic                       strobe_valid_r;
	logic [5:0]                 strobe_code_r;
	logic [5:0]                 link_code_r;
	logic                       stb_tgl_r;

	// receive-enabled time, saturating
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_cnt_r <= '0;
		end else if (!rx_enabled) begin
			rx_cnt_r <= '0;
		end else if (rx_cnt_r != RSSI_SETTLE_CYC) begin
			rx_cnt_r <= rx_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_r <= SSBR_STAT_RESET;
		end else begin
			status_r[SSBR_BIT_RSV_HI] <= 1'b0; // R10
			status_r[SSBR_BIT_RSV_LO] <= 1'b0; // R10
			status_r[SSBR_BIT_OSC]    <= osc_running; // R4
			status_r[SSBR_BIT_CIPHER] <= cipher_busy; // R6
			status_r[SSBR_BIT_TX_ACT] <= tx_active; // R7
			status_r[SSBR_BIT_LOCK]   <= pll_locked; // R8
			status_r[SSBR_BIT_RSSI]   <= rssi_ready ||
				(rx_enabled && rx_cnt_r == RSSI_SETTLE_CYC); // R9
			// a new underflow wins over a flush in the same cycle
			if (tx_underflow_evt) begin
				status_r[SSBR_BIT_UNDERRUN] <= 1'b1; // R5
			end else if (flush_acc) begin
				status_r[SSBR_BIT_UNDERRUN] <= 1'b0; // R5
			end
		end
	end

	// strobe toggle from the link: three flops, act when second and third differ
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stb_s1_r <= 1'b0;
			stb_s2_r <= 1'b0;
			stb_s3_r <= 1'b0;
		end else begin
			stb_s1_r <= stb_tgl_r;
			stb_s2_r <= stb_s1_r;
			stb_s3_r <= stb_s2_r;
		end
	end

	// link_code_r is stable for many sclk periods once the toggle is seen
	assign stb_evt    = stb_s2_r ^ stb_s3_r;
	assign stb_accept = stb_evt && link_code_r != SSBR_NOOP_STROBE && // R3
		(osc_running || link_code_r == SSBR_OSC_START); // R12
	assign flush_acc  = stb_accept && link_code_r == SSBR_FLUSH_TX; // R5

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strobe_valid_r <= 1'b0;
			strobe_code_r  <= 6'h00;
		end else begin
			strobe_valid_r <= stb_accept;
			if (stb_accept) begin
				strobe_code_r <= link_code_r;
			end
		end
	end

	assign strobe_valid = strobe_valid_r;
	assign strobe_code  = strobe_code_r;
	assign status_byte  = status_r;

	////////////////////////////////////////////////////////////////////////////
	// link side: frame decode on rising sclk

	logic        link_rst_n;
	logic [7:0]  stat_m_r;
	logic [7:0]  stat_s_r;
	logic [7:0]  stat_t_r;
	logic [7:0]  stat_q_r;
	logic [2:0]  bit_cnt_r;
	logic [6:0]  sh_r;
	logic [7:0]  byte_in;
	logic [1:0]  reg_left_r;
	logic        stb_pend_r;
	logic [2:0]  out_idx_r;
	logic        out_stat_r;
	ssbr_phase_t phase_r;

	// frame logic is cleared by the frame's own select, since sclk stops
	assign link_rst_n = nrst && !chip_select_n;
	assign byte_in    = {sh_r, si};

	// each status bit is a level: three flops, taken once second and third agree
	for (genvar gi = 0; gi < SSBR_STAT_W; gi++) begin : g_stat_sync
		always_ff @(posedge sclk or negedge nrst) begin
			if (!nrst) begin
				stat_m_r[gi] <= 1'b0;
				stat_s_r[gi] <= 1'b0;
				stat_t_r[gi] <= 1'b0;
				stat_q_r[gi] <= 1'b0;
			end else begin
				stat_m_r[gi] <= status_r[gi];
				stat_s_r[gi] <= stat_m_r[gi];
				stat_t_r[gi] <= stat_s_r[gi];
				if (stat_s_r[gi] == stat_t_r[gi]) begin
					stat_q_r[gi] <= stat_t_r[gi];
				end
			end
		end
	end

	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt_r <= 3'h0;
			sh_r      <= 7'h00;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			sh_r      <= byte_in[6:0];
		end
	end

	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			phase_r    <= SSBR_PH_HDR;
			reg_left_r <= 2'h0;
			stb_pend_r <= 1'b0;
		end else if (bit_cnt_r != SSBR_BIT_LAST) begin
			if (bit_cnt_r == 3'h0) begin
				stb_pend_r <= 1'b0;
			end
		end else begin
			case (phase_r)
				SSBR_PH_HDR: begin
					if (byte_in[SSBR_HDR_RAM_BIT]) begin
						phase_r <= SSBR_PH_RAM2;
					end else if (ssbr_is_strobe(byte_in)) begin
						stb_pend_r <= 1'b1; // R11
					end else if (byte_in[5:0] == SSBR_TXBUF_ADDR &&
							!byte_in[SSBR_HDR_RW_BIT]) begin
						phase_r <= SSBR_PH_TXW; // R2
					end else if (byte_in[5:0] == SSBR_TXBUF_ADDR ||
							byte_in[5:0] == SSBR_RXBUF_ADDR) begin
						phase_r <= SSBR_PH_DATA;
					end else begin
						phase_r    <= SSBR_PH_REG;
						reg_left_r <= SSBR_REG_LAST;
					end
				end
				SSBR_PH_REG: begin
					if (reg_left_r == 2'h0) begin
						phase_r <= SSBR_PH_HDR;
					end else begin
						reg_left_r <= reg_left_r - 2'h1;
					end
				end
				SSBR_PH_RAM2: begin
					phase_r <= SSBR_PH_DATA;
				end
				default: begin
					phase_r <= phase_r;
				end
			endcase
		end
	end

	// strobe code survives the frame so the system side can read it
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			link_code_r <= 6'h00;
		end else if (bit_cnt_r == SSBR_BIT_LAST && phase_r == SSBR_PH_HDR &&
				ssbr_is_strobe(byte_in)) begin
			link_code_r <= byte_in[5:0]; // R11
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link side: output on falling sclk

	// strobe runs on the last falling edge of its byte; the toggle survives deselect
	always_ff @(negedge sclk or negedge nrst) begin
		if (!nrst) begin
			stb_tgl_r <= 1'b0;
		end else if (stb_pend_r && out_idx_r == SSBR_BIT_LAST) begin
			stb_tgl_r <= !stb_tgl_r; // R11
		end
	end

	always_ff @(negedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			out_idx_r  <= 3'h0;
			out_stat_r <= 1'b1; // R1
		end else begin
			out_idx_r <= out_idx_r + 3'h1; // R13
			if (out_idx_r == SSBR_BIT_LAST) begin
				out_stat_r <= phase_r == SSBR_PH_HDR || phase_r == SSBR_PH_TXW; // R1 R2
			end
		end
	end

	assign so_oe = !chip_select_n;
	assign so    = so_oe && out_stat_r && stat_q_r[SSBR_BIT_LAST - out_idx_r]; // R13

	////////////////////////////////////////////////////////////////////////////
	// checks

	a_osc_bit: assert property (@(posedge clk) disable iff (!nrst) // R4
		status_r[SSBR_BIT_OSC] == $past(osc_running))
		else $error("oscillator bit does not follow oscillator");
	a_cipher_bit: assert property (@(posedge clk) disable iff (!nrst) // R6
		$rose(cipher_busy) |=> status_r[SSBR_BIT_CIPHER])
		else $error("cipher busy bit late");
	a_tx_bit: assert property (@(posedge clk) disable iff (!nrst) // R7
		$fell(tx_active) |=> !status_r[SSBR_BIT_TX_ACT])
		else $error("transmit active bit late");
	a_lock_bit: assert property (@(posedge clk) disable iff (!nrst) // R8
		pll_locked [*2] |-> status_r[SSBR_BIT_LOCK])
		else $error("lock bit not set while locked");
	a_signal_strength_valid_flag: assert property (@(posedge clk) disable iff (!nrst) // R9
		rx_enabled && rx_cnt_r == RSSI_SETTLE_CYC |=> status_r[SSBR_BIT_RSSI])
		else $error("signal strength not valid after settle time");
	a_rsv_zero: assert property (@(posedge clk) disable iff (!nrst) // R10
		!status_r[SSBR_BIT_RSV_HI] && !status_r[SSBR_BIT_RSV_LO])
		else $error("reserved status bits not zero");
	a_under_sticky: assert property (@(posedge clk) disable iff (!nrst) // R5
		status_r[SSBR_BIT_UNDERRUN] && !flush_acc |=> status_r[SSBR_BIT_UNDERRUN])
		else $error("underflow bit lost without flush");
	a_under_set: assert property (@(posedge clk) disable iff (!nrst) // R5
		tx_underflow_evt |=> status_r[SSBR_BIT_UNDERRUN])
		else $error("underflow bit not set");
	a_flush_clear: assert property (@(posedge clk) disable iff (!nrst) // R5
		flush_acc && !tx_underflow_evt |=> !status_r[SSBR_BIT_UNDERRUN] && strobe_valid)
		else $error("flush strobe did not clear underflow");
	a_strobe_gate: assert property (@(posedge clk) disable iff (!nrst) // R12
		strobe_valid |-> $past(osc_running) || strobe_code == SSBR_OSC_START)
		else $error("strobe accepted with oscillator off");
	a_noop_quiet: assert property (@(posedge clk) disable iff (!nrst) // R3
		stb_evt && link_code_r == SSBR_NOOP_STROBE |=> !strobe_valid)
		else $error("no-op strobe caused an action");
	a_so_status: assert property (@(negedge sclk) disable iff (!link_rst_n) // R1
		out_stat_r |-> so == stat_q_r[SSBR_BIT_LAST - out_idx_r])
		else $error("serial output does not carry status byte");
	a_txw_stream: assert property (@(negedge sclk) disable iff (!link_rst_n) // R2
		phase_r == SSBR_PH_TXW && out_idx_r == SSBR_BIT_LAST |=> out_stat_r)
		else $error("status not returned on transmit buffer byte");
	a_strobe_fall: assert property (@(negedge sclk) disable iff (!nrst) // R11
		stb_pend_r && out_idx_r == SSBR_BIT_LAST |=> stb_tgl_r != $past(stb_tgl_r))
		else $error("strobe not executed on last falling edge");

	c_flush: cover property (@(posedge clk) disable iff (!nrst) flush_acc);
	c_gated: cover property (@(posedge clk) disable iff (!nrst)
		stb_evt && !stb_accept && link_code_r != SSBR_NOOP_STROBE);
	c_txw: cover property (@(negedge sclk) disable iff (!link_rst_n)
		phase_r == SSBR_PH_TXW && out_idx_r == SSBR_BIT_LAST);
	c_rssi: cover property (@(posedge clk) disable iff (!nrst) $rose(status_r[SSBR_BIT_RSSI]));

endmodule

// >>> verification/ssbr_host_model.sv
// host side model that frames bytes on the serial configuration port
`timescale 1ns/1ps

module ssbr_host_model (
	output logic      sclk,
	output logic      chip_select_n,
	output logic      si,
	input  wire logic so
);

	initial begin
		sclk          = 1'b0;
		chip_select_n = 1'b1;
		si            = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one frame of n bytes; the link clock stands still outside it
	task automatic xfer(input logic [7:0] tx [4], input int n, output logic [7:0] rx [4]);
		chip_select_n = 1'b0;
		#24;
		for (int b = 0; b < n; b++) begin
			for (int i = 7; i >= 0; i--) begin
				si = tx[b][i];
				#24 sclk = 1'b1;
				rx[b][i] = so;
				#24 sclk = 1'b0;
			end
		end
		#24 chip_select_n = 1'b1;
		// released data line must not keep its last level
		si = ~si;
		#48;
	endtask

endmodule

// >>> verification/tb_top.sv
// self-checking bench of the serial status byte reporter
`timescale 1ns/1ps

module tb_top
	import ssbr_pkg::*;
;

	logic       clk;
	logic       nrst;
	logic       sclk;
	logic       chip_select_n;
	logic       si;
	logic       so;
	logic       so_oe;
	logic       osc_running;
	logic       tx_underflow_evt;
	logic       cipher_busy;
	logic       tx_active;
	logic       pll_locked;
	logic       rx_enabled;
	logic       rssi_ready;
	logic       strobe_valid;
	logic [5:0] strobe_code;
	logic [7:0] status_byte;
	logic [7:0] rx [4];
	logic [7:0] s;
	logic [7:0] tbl [7] = '{8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h5E, 8'h00};
	int         err_total;
	int         compares;
	int         stb_cnt;

	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	always @(posedge clk) begin
		if (strobe_valid === 1'b1) stb_cnt++;
	end

	ssbr_status_reporter #(.RSSI_SETTLE_CYC(15'd16)) dut (
		.clk(clk), .nrst(nrst), .sclk(sclk), .chip_select_n(chip_select_n), .si(si),
		.so(so), .so_oe(so_oe), .osc_running(osc_running),
		.tx_underflow_evt(tx_underflow_evt), .cipher_busy(cipher_busy),
		.tx_active(tx_active), .pll_locked(pll_locked), .rx_enabled(rx_enabled),
		.rssi_ready(rssi_ready), .strobe_valid(strobe_valid),
		.strobe_code(strobe_code), .status_byte(status_byte)
	);

	ssbr_host_model host (.sclk(sclk), .chip_select_n(chip_select_n), .si(si), .so(so));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic apply(input logic [7:0] v);
		cyc(1);
		osc_running = v[6];
		cipher_busy = v[4];
		tx_active   = v[3];
		pll_locked  = v[2];
		rssi_ready  = v[1];
		cyc(3);
	endtask

	// second byte of a double no-op frame carries fresh status; reserved bits masked
	task automatic read_stat(output logic [7:0] st);
		host.xfer('{8'h00, 8'h00, 8'h00, 8'h00}, 2, rx);
		st = rx[1] & 8'h7E;
	endtask

	task automatic strobe(input logic [5:0] c);
		host.xfer('{{2'b00, c}, 8'h00, 8'h00, 8'h00}, 1, rx);
		cyc(10);
	endtask

	task automatic stop_test();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#300000;
		err_total++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{nrst, osc_running, tx_underflow_evt, cipher_busy} = 4'h0;
		{tx_active, pll_locked, rx_enabled, rssi_ready}    = 4'h0;
		repeat (4) @(posedge clk);
		#1 nrst = 1'b1;
		cyc(3);

		foreach (tbl[k]) begin
			apply(tbl[k]);
			chk(status_byte & 8'h7E, tbl[k]);
			read_stat(s);
			chk(s, tbl[k]);
		end
		chk(stb_cnt[7:0], 8'h00);
		$display("test status bits done");

		apply(8'h40);
		tx_underflow_evt = 1'b1;
		cyc(1);
		tx_underflow_evt = 1'b0;
		cyc(3);
		read_stat(s);
		chk(s, 8'h60);
		read_stat(s);
		chk(s, 8'h60);
		apply(8'h00);
		strobe(SSBR_FLUSH_TX);
		chk(stb_cnt[7:0], 8'h00);
		read_stat(s);
		chk(s, 8'h20);
		strobe(SSBR_OSC_START);
		chk(stb_cnt[7:0], 8'h01);
		chk({2'b00, strobe_code}, 8'h01);
		apply(8'h40);
		strobe(SSBR_FLUSH_TX);
		chk(stb_cnt[7:0], 8'h02);
		chk({2'b00, strobe_code}, 8'h09);
		read_stat(s);
		chk(s, 8'h40);
		host.xfer('{8'h0F, 8'h12, 8'h34, 8'h00}, 3, rx);
		chk(rx[0] & 8'h7E, 8'h40);
		chk(rx[1] | rx[2], 8'h00);
		cyc(10);
		chk(stb_cnt[7:0], 8'h02);
		chk({7'h00, so_oe}, 8'h00);
		$display("test underflow and strobes done");

		apply(8'h5E);
		read_stat(s);
		chk(s, 8'h5E);
		host.xfer('{{2'b00, SSBR_TXBUF_ADDR}, 8'hA5, 8'h5A, 8'hC3}, 4, rx);
		chk(rx[0] & 8'h7E, 8'h5E);
		for (int b = 1; b < 4; b++) begin
			chk(rx[b] & 8'h7E, 8'h5E);
		end
		$display("test tx buffer write done");

		apply(8'h40);
		rx_enabled = 1'b1;
		cyc(8);
		chk({7'h00, status_byte[SSBR_BIT_RSSI]}, 8'h00);
		cyc(8);
		chk({7'h00, status_byte[SSBR_BIT_RSSI]}, 8'h00);
		cyc(1);
		chk({7'h00, status_byte[SSBR_BIT_RSSI]}, 8'h01);
		read_stat(s);
		chk(s, 8'h42);
		$display("test signal strength settle done");
		stop_test();
	end

endmodule
